/* File: design/cbb_bitop.sv */
/*
 Byte-operand bit unit exchanging one selected bit with the carry flag.
 Assumes the core applies its outputs only while executing a command.
*/
`timescale 1ns/1ps
module cbb_bitop (
    // link to core
    cbb_bit_if.unit bif
);
    import cbb_pkg::*;
    logic sel;

    always_comb begin
        sel = bif.operand_in[bif.bit_sel];
        bif.carry_out = bif.carry_in;
        bif.operand_out = bif.operand_in;
        bif.carry_we = 1'b0;
        bif.operand_we = 1'b0;
        case (bif.op)
            BIT_XOR_INTO_CARRY: begin
                bif.carry_out = bif.carry_in ^ sel;
                bif.carry_we = 1'b1;
            end
            INVERTED_BIT_XOR_INTO_CARRY: begin
                bif.carry_out = bif.carry_in ^ ~sel;
                bif.carry_we = 1'b1;
            end
            BIT_LOAD_TO_CARRY: begin
                bif.carry_out = sel;
                bif.carry_we = 1'b1;
            end
            INVERTED_BIT_LOAD_TO_CARRY: begin
                bif.carry_out = ~sel;
                bif.carry_we = 1'b1;
            end
            CARRY_STORE_TO_BIT: begin
                bif.operand_out[bif.bit_sel] = bif.carry_in;
                bif.operand_we = 1'b1;
            end
            INVERTED_CARRY_STORE_TO_BIT: begin
                bif.operand_out[bif.bit_sel] = ~bif.carry_in;
                bif.operand_we = 1'b1;
            end
            default: begin
            end
        endcase
    end
endmodule : cbb_bitop

/* File: design/cbb_consts.svh */
/*
 Constants of the carry-bit and branch slice: register offsets, field positions, codes, reset values.
 Assumes inclusion by bare name from package and modules.
*/
`ifndef CBB_CONSTS_SVH
`define CBB_CONSTS_SVH
`define CBB_ADDR_W 8
`define CBB_OFS_FLAGS 8'h00
`define CBB_OFS_OPERAND 8'h04
`define CBB_OFS_PC 8'h08
`define CBB_OFS_TARGET 8'h0C
`define CBB_OFS_CMD 8'h10
`define CBB_OFS_STATUS 8'h14
`define CBB_FLG_C 0
`define CBB_FLG_V 1
`define CBB_FLG_Z 2
`define CBB_FLG_N 3
`define CBB_FLG_W 4
`define CBB_CMD_OP_LSB 0
`define CBB_CMD_OP_MSB 3
`define CBB_CMD_BIT_LSB 4
`define CBB_CMD_BIT_MSB 6
`define CBB_CMD_CC_LSB 8
`define CBB_CMD_CC_MSB 11
`define CBB_CMD_LEN_LSB 12
`define CBB_CMD_LEN_MSB 15
`define CBB_ST_TAKEN 0
`define CBB_ST_STKERR 1
`define CBB_ST_ILLOP 2
`define CBB_ST_DEPTH_LSB 8
`define CBB_RST_PC 32'h0000_0000
`define CBB_RST_WORD 32'h0000_0000
`define CBB_OP_BXC 4'h0
`define CBB_OP_IBXC 4'h1
`define CBB_OP_BLC 4'h2
`define CBB_OP_IBLC 4'h3
`define CBB_OP_CSB 4'h4
`define CBB_OP_ICSB 4'h5
`define CBB_OP_BCOND 4'h6
`define CBB_OP_JUMP 4'h7
`define CBB_OP_RCALL 4'h8
`define CBB_OP_ACALL 4'h9
`define CBB_OP_RET 4'hA
`endif

/* File: design/cbb_core.sv */
/*
 Carry-bit operation and branch evaluation slice with an AHB-Lite register slave.
 Assumes a single AHB-Lite master on hclk, word-sized single transfers, hready looped from hreadyout.
*/
`timescale 1ns/1ps
`include "cbb_consts.svh"
module cbb_core #(
    parameter int STACK_DEPTH = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import cbb_pkg::*;
    localparam int CW = $clog2(STACK_DEPTH + 1);

    cbb_bit_if bif ();
    cbb_stk_if #(.CW(CW)) stk ();

    cbb_bitop u_bitop (
        .bif(bif)
    );

    cbb_retstack #(.DEPTH(STACK_DEPTH), .CW(CW)) u_stack (
        .hclk(hclk),
        .hresetn(hresetn),
        .stk(stk)
    );

    cbb_state_t state;
    logic [`CBB_FLG_W-1:0] flags;
    logic [7:0] operand;
    logic [31:0] pc;
    logic [31:0] target;
    logic [31:0] cmd;
    logic taken;
    logic stk_err;
    logic ill_err;
    logic dp_valid;
    logic dp_write;
    logic [`CBB_ADDR_W-1:0] dp_addr;
    logic rd_ok;
    logic [31:0] rd_mux;
    logic next_taken;

    wire st_idle = (state == CBB_ST_IDLE);
    wire st_exec = (state == CBB_ST_EXEC);
    wire st_ret = (state == CBB_ST_RET);
    wire wr_done = dp_valid && dp_write && hreadyout;
    wire cbb_op_t cur_op = cbb_op_t'(cmd[`CBB_CMD_OP_MSB:`CBB_CMD_OP_LSB]);
    wire cbb_cond_t cur_cc = cbb_cond_t'(cmd[`CBB_CMD_CC_MSB:`CBB_CMD_CC_LSB]);
    wire [2:0] bit_sel = cmd[`CBB_CMD_BIT_MSB:`CBB_CMD_BIT_LSB];
    wire [31:0] pc_seq = pc + 32'(cmd[`CBB_CMD_LEN_MSB:`CBB_CMD_LEN_LSB]);
    wire [31:0] rel_dest = pc_seq + target;
    wire cond_ok = cbb_cond_true(cur_cc, flags);
    wire is_call = (cur_op == RELATIVE_SUBROUTINE_CALL) || (cur_op == ABSOLUTE_SUBROUTINE_CALL);
    wire is_ret = (cur_op == SUBROUTINE_RETURN);
    wire illegal = (cur_op > SUBROUTINE_RETURN);
    wire bit_now = operand[bit_sel];
    wire [7:0] sel_mask = 8'h01 << bit_sel;

    // bus: one wait state on reads, stall while a command runs
    assign hresp = 1'b0;
    assign hreadyout = st_idle && (!dp_valid || dp_write || rd_ok);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= '0;
        end else if (hready) begin
            dp_valid <= hsel && htrans[1];
            dp_write <= hwrite;
            dp_addr <= haddr[`CBB_ADDR_W-1:0];
        end
    end

    always_comb begin
        unique case (dp_addr)
            `CBB_OFS_FLAGS: rd_mux = 32'(flags);
            `CBB_OFS_OPERAND: rd_mux = 32'(operand);
            `CBB_OFS_PC: rd_mux = pc;
            `CBB_OFS_TARGET: rd_mux = target;
            `CBB_OFS_CMD: rd_mux = cmd;
            `CBB_OFS_STATUS: begin
                rd_mux = '0;
                rd_mux[`CBB_ST_TAKEN] = taken;
                rd_mux[`CBB_ST_STKERR] = stk_err;
                rd_mux[`CBB_ST_ILLOP] = ill_err;
                rd_mux[`CBB_ST_DEPTH_LSB +: CW] = stk.count;
            end
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ok <= 1'b0;
            hrdata <= `CBB_RST_WORD;
        end else begin
            rd_ok <= dp_valid && !dp_write && st_idle && !rd_ok;
            if (dp_valid && !dp_write && !rd_ok) begin
                hrdata <= rd_mux;
            end
        end
    end

    // sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= CBB_ST_IDLE;
        end else begin
            unique case (state)
                CBB_ST_IDLE: if (wr_done && dp_addr == `CBB_OFS_CMD) begin
                    state <= CBB_ST_EXEC;
                end
                CBB_ST_EXEC: state <= (is_ret && !stk.empty) ? CBB_ST_RET : CBB_ST_IDLE;
                CBB_ST_RET: state <= CBB_ST_IDLE;
                default: state <= CBB_ST_IDLE;
            endcase
        end
    end

    assign bif.op = cur_op;
    assign bif.bit_sel = bit_sel;
    assign bif.operand_in = operand;
    assign bif.carry_in = flags[`CBB_FLG_C];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= '0;
        end else if (wr_done && dp_addr == `CBB_OFS_FLAGS) begin
            flags <= hwdata[`CBB_FLG_W-1:0];
        end else if (st_exec && bif.carry_we) begin
            flags[`CBB_FLG_C] <= bif.carry_out;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            operand <= '0;
        end else if (wr_done && dp_addr == `CBB_OFS_OPERAND) begin
            operand <= hwdata[7:0];
        end else if (st_exec && bif.operand_we) begin
            operand <= bif.operand_out;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            target <= `CBB_RST_WORD;
            cmd <= `CBB_RST_WORD;
        end else begin
            if (wr_done && dp_addr == `CBB_OFS_TARGET) begin
                target <= hwdata;
            end
            if (wr_done && dp_addr == `CBB_OFS_CMD) begin
                cmd <= hwdata;
            end
        end
    end

    // calls push the sequential address in the same cycle as the jump
    assign stk.push = st_exec && is_call;
    assign stk.pop = st_exec && is_ret;
    assign stk.wdata = pc_seq;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc <= `CBB_RST_PC;
        end else if (wr_done && dp_addr == `CBB_OFS_PC) begin
            pc <= hwdata;
        end else if (st_ret) begin
            pc <= stk.rdata;
        end else if (st_exec) begin
            case (cur_op)
                CONDITIONAL_BRANCH: pc <= cond_ok ? rel_dest : pc_seq;
                UNCONDITIONAL_JUMP: pc <= target;
                RELATIVE_SUBROUTINE_CALL: pc <= rel_dest;
                ABSOLUTE_SUBROUTINE_CALL: pc <= target;
                SUBROUTINE_RETURN: if (stk.empty) begin
                    pc <= pc_seq;
                end
                default: pc <= pc_seq;
            endcase
        end
    end

    always_comb begin
        next_taken = 1'b0;
        if (cur_op == CONDITIONAL_BRANCH) begin
            next_taken = cond_ok;
        end else if (cur_op == UNCONDITIONAL_JUMP || is_call) begin
            next_taken = 1'b1;
        end else if (is_ret) begin
            next_taken = !stk.empty;
        end
    end

    // error flags: write one to clear, a new event wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            taken <= 1'b0;
            stk_err <= 1'b0;
            ill_err <= 1'b0;
        end else if (st_exec) begin
            taken <= next_taken;
            stk_err <= stk_err || (is_call && stk.full) || (is_ret && stk.empty);
            ill_err <= ill_err || illegal;
        end else if (wr_done && dp_addr == `CBB_OFS_STATUS) begin
            stk_err <= stk_err && !hwdata[`CBB_ST_STKERR];
            ill_err <= ill_err && !hwdata[`CBB_ST_ILLOP];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_xor;
        st_exec && cur_op == BIT_XOR_INTO_CARRY |=> flags[`CBB_FLG_C] == ($past(flags[`CBB_FLG_C]) ^ $past(bit_now));
    endproperty
    a_xor: assert property (p_xor) else $error("xor into carry wrong");
    property p_ixor;
        st_exec && cur_op == INVERTED_BIT_XOR_INTO_CARRY |=> flags[`CBB_FLG_C] == ($past(flags[`CBB_FLG_C]) ^ !$past(bit_now));
    endproperty
    a_ixor: assert property (p_ixor) else $error("inverted xor into carry wrong");
    property p_ld;
        st_exec && cur_op == BIT_LOAD_TO_CARRY |=> flags[`CBB_FLG_C] == $past(bit_now) && $stable(operand);
    endproperty
    a_ld: assert property (p_ld) else $error("bit load to carry wrong");
    property p_ild;
        st_exec && cur_op == INVERTED_BIT_LOAD_TO_CARRY |=> flags[`CBB_FLG_C] == !$past(bit_now);
    endproperty
    a_ild: assert property (p_ild) else $error("inverted bit load wrong");
    property p_st;
        st_exec && cur_op == CARRY_STORE_TO_BIT |=> operand[$past(bit_sel)] == $past(flags[`CBB_FLG_C]);
    endproperty
    a_st: assert property (p_st) else $error("carry store to bit wrong");
    property p_ist;
        st_exec && cur_op == INVERTED_CARRY_STORE_TO_BIT |=> operand[$past(bit_sel)] == !$past(flags[`CBB_FLG_C]);
    endproperty
    a_ist: assert property (p_ist) else $error("inverted carry store wrong");
    property p_byte;
        st_exec && bif.operand_we |=> ((operand ^ $past(operand)) & ~$past(sel_mask)) == 8'h00;
    endproperty
    a_byte: assert property (p_byte) else $error("store touched another bit");
    property p_bcc;
        st_exec && cur_op == CONDITIONAL_BRANCH |=> pc == ($past(cond_ok) ? $past(rel_dest) : $past(pc_seq));
    endproperty
    a_bcc: assert property (p_bcc) else $error("branch destination wrong");
    property p_hi;
        st_exec && cur_op == CONDITIONAL_BRANCH && cur_cc == BRANCH_HIGHER
            && !flags[`CBB_FLG_C] && !flags[`CBB_FLG_Z] |=> pc == $past(rel_dest) ##1 st_idle;
    endproperty
    a_hi: assert property (p_hi) else $error("higher branch not taken");
    property p_lt;
        st_exec && cur_op == CONDITIONAL_BRANCH && cur_cc == BRANCH_SIGNED_LESS
            && (flags[`CBB_FLG_N] == flags[`CBB_FLG_V]) |=> pc == $past(pc_seq);
    endproperty
    a_lt: assert property (p_lt) else $error("signed less taken wrongly");
    property p_jmp;
        st_exec && cur_op == UNCONDITIONAL_JUMP |=> pc == $past(target) && taken && $stable(flags);
    endproperty
    a_jmp: assert property (p_jmp) else $error("jump wrong");
    property p_call;
        st_exec && is_call && !stk.full |=> stk.count == $past(stk.count) + 1'b1
            && pc == ($past(cur_op) == ABSOLUTE_SUBROUTINE_CALL ? $past(target) : $past(rel_dest));
    endproperty
    a_call: assert property (p_call) else $error("call did not save and jump");
    property p_ret;
        st_exec && is_ret && !stk.empty |=> st_ret ##1 pc == $past(stk.rdata) && st_idle;
    endproperty
    a_ret: assert property (p_ret) else $error("return did not restore address");
    property p_latest;
        st_exec && cur_op == CONDITIONAL_BRANCH |=> taken == $past(cbb_cond_true(cur_cc, flags));
    endproperty
    a_latest: assert property (p_latest) else $error("branch used stale flags");
endmodule : cbb_core

/* File: design/cbb_ifs.sv */
/*
 Interfaces between the slice's own modules: bit unit and return-address store.
 Assumes cbb_pkg compiled first.
*/
`timescale 1ns/1ps
interface cbb_bit_if;
    cbb_pkg::cbb_op_t op;
    logic [2:0] bit_sel;
    logic [7:0] operand_in;
    logic carry_in;
    logic carry_out;
    logic [7:0] operand_out;
    logic carry_we;
    logic operand_we;
    modport core (output op, bit_sel, operand_in, carry_in, input carry_out, operand_out, carry_we, operand_we);
    modport unit (input op, bit_sel, operand_in, carry_in, output carry_out, operand_out, carry_we, operand_we);
endinterface : cbb_bit_if

interface cbb_stk_if #(parameter int CW = 4);
    logic push;
    logic pop;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [CW-1:0] count;
    logic full;
    logic empty;
    modport core (output push, pop, wdata, input rdata, count, full, empty);
    modport mem (input push, pop, wdata, output rdata, count, full, empty);
endinterface : cbb_stk_if

/* File: design/cbb_pkg.sv */
/*
 Types of the carry-bit and branch slice: operations, conditions, states, condition evaluation.
 Assumes cbb_consts.svh on the include path.
*/
`include "cbb_consts.svh"
package cbb_pkg;
    typedef enum logic [3:0] {
        BIT_XOR_INTO_CARRY = `CBB_OP_BXC,
        INVERTED_BIT_XOR_INTO_CARRY = `CBB_OP_IBXC,
        BIT_LOAD_TO_CARRY = `CBB_OP_BLC,
        INVERTED_BIT_LOAD_TO_CARRY = `CBB_OP_IBLC,
        CARRY_STORE_TO_BIT = `CBB_OP_CSB,
        INVERTED_CARRY_STORE_TO_BIT = `CBB_OP_ICSB,
        CONDITIONAL_BRANCH = `CBB_OP_BCOND,
        UNCONDITIONAL_JUMP = `CBB_OP_JUMP,
        RELATIVE_SUBROUTINE_CALL = `CBB_OP_RCALL,
        ABSOLUTE_SUBROUTINE_CALL = `CBB_OP_ACALL,
        SUBROUTINE_RETURN = `CBB_OP_RET
    } cbb_op_t;

    typedef enum logic [3:0] {
        BRANCH_ALWAYS = 4'h0, BRANCH_NEVER = 4'h1, BRANCH_HIGHER = 4'h2, BRANCH_LOWER_OR_SAME = 4'h3,
        BRANCH_CARRY_CLEAR = 4'h4, BRANCH_CARRY_SET = 4'h5, BRANCH_NOT_EQUAL = 4'h6, BRANCH_EQUAL = 4'h7,
        BRANCH_OVERFLOW_CLEAR = 4'h8, BRANCH_OVERFLOW_SET = 4'h9, BRANCH_PLUS = 4'hA, BRANCH_MINUS = 4'hB,
        BRANCH_SIGNED_GREATER_EQUAL = 4'hC, BRANCH_SIGNED_LESS = 4'hD,
        BRANCH_SIGNED_GREATER = 4'hE, BRANCH_SIGNED_LESS_EQUAL = 4'hF
    } cbb_cond_t;

    typedef enum logic [2:0] {
        CBB_ST_IDLE = 3'b001,
        CBB_ST_EXEC = 3'b010,
        CBB_ST_RET = 3'b100
    } cbb_state_t;

    function automatic logic cbb_cond_true(input cbb_cond_t cc, input logic [`CBB_FLG_W-1:0] f);
        logic c;
        logic v;
        logic z;
        logic n;
        logic r;
        c = f[`CBB_FLG_C];
        v = f[`CBB_FLG_V];
        z = f[`CBB_FLG_Z];
        n = f[`CBB_FLG_N];
        unique case (cc)
            BRANCH_ALWAYS, BRANCH_NEVER: r = 1'b1;
            BRANCH_HIGHER, BRANCH_LOWER_OR_SAME: r = ~(c | z);
            BRANCH_CARRY_CLEAR, BRANCH_CARRY_SET: r = ~c;
            BRANCH_NOT_EQUAL, BRANCH_EQUAL: r = ~z;
            BRANCH_OVERFLOW_CLEAR, BRANCH_OVERFLOW_SET: r = ~v;
            BRANCH_PLUS, BRANCH_MINUS: r = ~n;
            BRANCH_SIGNED_GREATER_EQUAL, BRANCH_SIGNED_LESS: r = ~(n ^ v);
            BRANCH_SIGNED_GREATER, BRANCH_SIGNED_LESS_EQUAL: r = ~(z | (n ^ v));
        endcase
        // odd codes are the complementary condition
        return r ^ cc[0];
    endfunction : cbb_cond_true
endpackage : cbb_pkg

/* File: design/cbb_retstack.sv */
/*
 Return-address store, last in first out, registered read data.
 Assumes nothing of callers: a push when full or a pop when empty is ignored.
*/
`timescale 1ns/1ps
`include "cbb_consts.svh"
module cbb_retstack #(
    parameter int DEPTH = 8,
    parameter int CW = 4
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link to core
    cbb_stk_if.mem stk
);
    import cbb_pkg::*;
    localparam int IW = $clog2(DEPTH);
    logic [31:0] mem [DEPTH];

    if (DEPTH < 2 || DEPTH > 255 || CW != $clog2(DEPTH + 1)) begin : g_bad
        $error("cbb_retstack: unsupported depth or count width");
    end

    assign stk.full = (stk.count == CW'(DEPTH));
    assign stk.empty = (stk.count == '0);

    always_ff @(posedge hclk) begin
        if (stk.push && !stk.full) begin
            mem[stk.count[IW-1:0]] <= stk.wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stk.count <= '0;
        end else if (stk.push && !stk.full) begin
            stk.count <= stk.count + 1'b1;
        end else if (stk.pop && !stk.empty) begin
            stk.count <= stk.count - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stk.rdata <= `CBB_RST_WORD;
        end else if (stk.pop && !stk.empty) begin
            stk.rdata <= mem[IW'(stk.count - 1'b1)];
        end
    end

    // last accepted push, kept apart from the array for the check below
    logic [31:0] top_word;
    logic top_valid;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            top_word <= `CBB_RST_WORD;
            top_valid <= 1'b0;
        end else if (stk.push && !stk.full) begin
            top_word <= stk.wdata;
            top_valid <= 1'b1;
        end else if (stk.pop && !stk.empty) begin
            top_valid <= 1'b0;
        end
    end

    property p_lifo;
        @(posedge hclk) disable iff (!hresetn)
        stk.pop && !stk.empty && top_valid |=> stk.rdata == $past(top_word);
    endproperty
    a_lifo: assert property (p_lifo) else $error("return store did not give back last pushed address");
endmodule : cbb_retstack

/* File: sim/tb_top.sv */
/*
 Self-checking bench of the carry-bit and branch slice, driven over its AHB-Lite slave.
 Assumes the design files compiled first and cbb_consts.svh on the include path.
*/
`timescale 1ns/1ps
`include "cbb_consts.svh"
module tb_top;
    import cbb_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic rdy_s;
    logic [31:0] rd_s;
    logic [31:0] r;
    logic [7:0] opnd;
    logic [7:0] x;
    logic [2:0] b;
    logic c;
    logic e;
    int bad_count = 0;
    int compares = 0;
    always #50 hclk = ~hclk;
    // mid-cycle copies equal what the next rising edge samples
    always @(negedge hclk) begin
        rdy_s <= hreadyout;
        rd_s <= hrdata;
    end
    cbb_core #(.STACK_DEPTH(2)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
    );
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (rdy_s !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = rd_s;
    endtask : xfer
    function automatic logic [31:0] cmdw(input logic [3:0] op, input logic [2:0] bt, input logic [3:0] cc,
        input logic [3:0] len);
        return {16'h0000, len, cc, 1'b0, bt, op};
    endfunction : cmdw
    // flags: [0] carry [1] overflow [2] zero [3] negative
    function automatic logic want(input logic [3:0] cc, input logic [3:0] f);
        logic [7:0] t;
        t = {~(f[2] | (f[3] ^ f[1])), ~(f[3] ^ f[1]), ~f[3], ~f[1], ~f[2], ~f[0], ~(f[0] | f[2]), 1'b1};
        return t[cc[3:1]] ^ cc[0];
    endfunction : want
    initial begin
        repeat (40000) @(posedge hclk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a <= 20; a += 4) begin
            xfer(1'b0, 8'(a), 32'h0);
            chk(r, `CBB_RST_WORD);
            chk(32'(hresp), 32'h0000_0000);
        end
        xfer(1'b1, 8'h18, 32'hFFFF_FFFF);
        xfer(1'b0, 8'h18, 32'h0);
        chk(r, 32'h0000_0000);
        for (int op = 0; op < 6; op++) begin
            for (int k = 0; k < 2; k++) begin
                c = k[0];
                b = k[0] ? 3'(op) : 3'(7 - op);
                opnd = k[0] ? 8'hC3 : 8'h5A;
                xfer(1'b1, `CBB_OFS_FLAGS, {28'h0, 3'b101, c});
                xfer(1'b1, `CBB_OFS_OPERAND, {24'h0, opnd});
                xfer(1'b1, `CBB_OFS_PC, 32'h0000_0100);
                xfer(1'b1, `CBB_OFS_CMD, cmdw(4'(op), b, 4'h0, 4'h2));
                e = opnd[b];
                case (op)
                    0: e = c ^ e;
                    1: e = c ^ ~e;
                    3: e = ~e;
                    4, 5: e = c;
                    default: e = e;
                endcase
                x = opnd;
                if (op >= 4) begin
                    x[b] = (op == 4) ? c : ~c;
                end
                xfer(1'b0, `CBB_OFS_FLAGS, 32'h0);
                chk(r, {28'h0, 3'b101, e});
                xfer(1'b0, `CBB_OFS_OPERAND, 32'h0);
                chk(r, {24'h0, x});
                xfer(1'b0, `CBB_OFS_PC, 32'h0);
                chk(r, 32'h0000_0102);
            end
        end
        xfer(1'b1, `CBB_OFS_TARGET, 32'h0000_0020);
        for (int cc = 0; cc < 16; cc++) begin
            for (int f = 0; f < 16; f++) begin
                xfer(1'b1, `CBB_OFS_FLAGS, 32'(f));
                xfer(1'b1, `CBB_OFS_PC, 32'h0000_0100);
                xfer(1'b1, `CBB_OFS_CMD, cmdw(4'h6, 3'h0, 4'(cc), 4'h2));
                e = want(4'(cc), 4'(f));
                xfer(1'b0, `CBB_OFS_PC, 32'h0);
                chk(r, e ? 32'h0000_0122 : 32'h0000_0102);
                xfer(1'b0, `CBB_OFS_STATUS, 32'h0);
                chk(r, {31'h0, e});
            end
        end
        // carry written by a bit load feeds the very next branch
        xfer(1'b1, `CBB_OFS_FLAGS, 32'h0);
        xfer(1'b1, `CBB_OFS_OPERAND, 32'h0000_0001);
        xfer(1'b1, `CBB_OFS_PC, 32'h0000_0300);
        xfer(1'b1, `CBB_OFS_TARGET, 32'h0000_0040);
        xfer(1'b1, `CBB_OFS_CMD, cmdw(4'h2, 3'h0, 4'h0, 4'h2));
        xfer(1'b1, `CBB_OFS_CMD, cmdw(4'h6, 3'h0, 4'h5, 4'h2));
        xfer(1'b0, `CBB_OFS_PC, 32'h0);
        chk(r, 32'h0000_0344);
        xfer(1'b1, `CBB_OFS_FLAGS, 32'h0);
        xfer(1'b1, `CBB_OFS_PC, 32'h0000_0200);
        xfer(1'b1, `CBB_OFS_TARGET, 32'h0000_0400);
        xfer(1'b1, `CBB_OFS_CMD, cmdw(4'h7, 3'h0, 4'h1, 4'h4));
        xfer(1'b0, `CBB_OFS_PC, 32'h0);
        chk(r, 32'h0000_0400);
        xfer(1'b1, `CBB_OFS_TARGET, 32'h0000_0800);
        xfer(1'b1, `CBB_OFS_CMD, cmdw(4'h9, 3'h0, 4'h0, 4'h4));
        xfer(1'b0, `CBB_OFS_PC, 32'h0);
        chk(r, 32'h0000_0800);
        xfer(1'b1, `CBB_OFS_TARGET, 32'h0000_0010);
        xfer(1'b1, `CBB_OFS_CMD, cmdw(4'h8, 3'h0, 4'h0, 4'h2));
        xfer(1'b0, `CBB_OFS_PC, 32'h0);
        chk(r, 32'h0000_0812);
        // third call overflows the two-entry store
        xfer(1'b1, `CBB_OFS_TARGET, 32'h0000_0900);
        xfer(1'b1, `CBB_OFS_CMD, cmdw(4'h9, 3'h0, 4'h0, 4'h4));
        xfer(1'b0, `CBB_OFS_PC, 32'h0);
        chk(r, 32'h0000_0900);
        xfer(1'b0, `CBB_OFS_STATUS, 32'h0);
        chk(r, 32'h0000_0203);
        xfer(1'b1, `CBB_OFS_STATUS, 32'h0000_0002);
        xfer(1'b1, `CBB_OFS_CMD, cmdw(4'hA, 3'h0, 4'h0, 4'h2));
        xfer(1'b0, `CBB_OFS_PC, 32'h0);
        chk(r, 32'h0000_0802);
        xfer(1'b1, `CBB_OFS_CMD, cmdw(4'hA, 3'h0, 4'h0, 4'h2));
        xfer(1'b0, `CBB_OFS_PC, 32'h0);
        chk(r, 32'h0000_0404);
        xfer(1'b1, `CBB_OFS_CMD, cmdw(4'hA, 3'h0, 4'h0, 4'h2));
        xfer(1'b0, `CBB_OFS_PC, 32'h0);
        chk(r, 32'h0000_0406);
        xfer(1'b0, `CBB_OFS_STATUS, 32'h0);
        chk(r, 32'h0000_0002);
        // illegal op steps the pc, clears taken and sets its sticky flag
        xfer(1'b1, `CBB_OFS_CMD, cmdw(4'hB, 3'h0, 4'h0, 4'h2));
        xfer(1'b0, `CBB_OFS_PC, 32'h0);
        chk(r, 32'h0000_0408);
        xfer(1'b0, `CBB_OFS_STATUS, 32'h0);
        chk(r, 32'h0000_0006);
        xfer(1'b1, `CBB_OFS_STATUS, 32'h0000_0006);
        xfer(1'b0, `CBB_OFS_STATUS, 32'h0);
        chk(r, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : tb_top
